/* rcf_pkg.sv */
// ==========================================================
// reset cause flags: shared constants
package rcf_pkg;
  // register word indices; byte address is four times the index
  localparam logic [5:0] REG_FLAGS_IDX = 6'h03;
  localparam logic [5:0] REG_MASK_IDX = 6'h04;

  // bit positions inside the flag and mask registers
  localparam int POWER_ON_FLAG_BIT = 6;
  localparam int LOW_VOLTAGE_FLAG_BIT = 5;
  localparam int WATCHDOG_RESET_FLAG_BIT = 3;
  localparam int OSC_MONITOR_RESET_FLAG_BIT = 1;
  localparam int PLL_MONITOR_RESET_FLAG_BIT = 0;

  // implemented flag bits, all others read zero
  localparam logic [7:0] FLAGS_IMPL_MASK = 8'h6B;
  // power-on value: power-on and low-voltage set, the rest clear
  localparam logic [7:0] FLAGS_RESET_VAL = 8'h60;
  localparam logic [7:0] MASK_RESET_VAL = 8'h00;
  localparam logic [31:0] RDATA_RESET_VAL = 32'h0000_0000;

  // reset request pins, each with its own synchroniser
  localparam int NUM_SOURCES = 6;
endpackage

/* rcf_reset_cause_flags.sv */
`timescale 1ns/10ps
// How it works
// - power-on sets power-on flag bit 6; other resets leave it alone.
// - any low-voltage reset on core, flash or io supply sets bit 5.
// - power-on also sets the low-voltage flag; other resets keep it.
// - a watchdog timer reset sets bit 3.
// - a crystal clock loss reset sets the oscillator monitor flag, bit 1.
// - a PLL clock loss reset sets the PLL monitor flag, bit 0.
// - power-on clears bits 3, 1, 0; other resets keep them.
// - apart from power-on clearing bits 3, 1, 0, a flag clears only when software writes one to it.
module rcf_reset_cause_flags (
  input wire logic clk,
  input wire logic rst_b,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // reset sources from monitors, asynchronous levels
  input wire logic coreLowVoltageReset,
  input wire logic flashSupplyLowVoltageReset,
  input wire logic ioSupplyLowVoltageReset,
  input wire logic watchdogTimerReset,
  input wire logic oscMonitorReset,
  input wire logic pllMonitorReset,
  // interrupt
  output logic irq_o
);

  // ==========================================================
  // input synchronisers
  // source order: 0 pll, 1 osc, 2 watchdog, 3 core, 4 flash, 5 io supply
  logic [rcf_pkg::NUM_SOURCES-1:0] srcRaw;
  logic [rcf_pkg::NUM_SOURCES-1:0] srcMeta_q;
  logic [rcf_pkg::NUM_SOURCES-1:0] srcSync_q;
  logic lowVoltageSync;

  // every pin gets its own pair of flops; a gate in front of the first
  // stage could turn skew between two supply monitors into a glitch
  // limitation: a request must stand for at least two clocks to be seen,
  // which the monitors meet by holding their reset request far longer;
  // the flags then trail the pins by three edges
  assign srcRaw = {ioSupplyLowVoltageReset, flashSupplyLowVoltageReset, coreLowVoltageReset,
                   watchdogTimerReset, oscMonitorReset, pllMonitorReset};

  // two flops per source; the first is read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < rcf_pkg::NUM_SOURCES; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          srcMeta_q[gi] <= 1'b0;
          srcSync_q[gi] <= 1'b0;
        end else begin
          srcMeta_q[gi] <= srcRaw[gi];
          srcSync_q[gi] <= srcMeta_q[gi];
        end
      end
    end
  endgenerate

  // the three supply domains share one flag, merged once synchronised
  assign lowVoltageSync = |srcSync_q[5:3];

  // ==========================================================
  // bus slave
  // request taken at edge n with ack low, ack stands in cycle n+1 only;
  // read data is captured with the ack so it is settled when sampled,
  // and a write lands on the edge where the master sees ack high.
  // the gap the master leaves after each ack keeps requests apart
  logic ack_q;
  logic ack_d;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  logic busReq;
  logic wrCommit;
  logic hitFlags;
  logic hitMask;
  // flag and mask state live below; declared here for the read mux
  logic [7:0] flags_q;
  logic [7:0] mask_q;

  assign busReq = cyc_i & stb_i;
  assign hitFlags = (adr_i[7:2] == rcf_pkg::REG_FLAGS_IDX);
  assign hitMask = (adr_i[7:2] == rcf_pkg::REG_MASK_IDX);
  // writes land on the edge where the master samples ack; a write with
  // byte lane 0 off is still acked but changes nothing
  assign wrCommit = busReq & we_i & ack_q & sel_i[0];

  // one-wait-state ack, read data captured with it; unmapped reads zero
  always_comb begin
    ack_d = busReq & ~ack_q;
    rdData_d = rdData_q;
    if (ack_d && !we_i) begin
      rdData_d = rcf_pkg::RDATA_RESET_VAL;
      if (hitFlags) begin
        rdData_d[7:0] = flags_q & rcf_pkg::FLAGS_IMPL_MASK;
      end else if (hitMask) begin
        rdData_d[7:0] = mask_q;
      end
    end
  end

  // bus registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      rdData_q <= rcf_pkg::RDATA_RESET_VAL;
    end else begin
      ack_q <= ack_d;
      rdData_q <= rdData_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdData_q;

  // ==========================================================
  // reset cause flags and interrupt mask
  // the flags are the interrupt status word; the mask has its layout.
  // a cause that is still asserted refills its flag every cycle, so
  // software cannot lose it by clearing early: it must wait for release
  logic [7:0] flags_d;
  logic [7:0] mask_d;
  logic [7:0] setVec;
  logic [7:0] clrVec;
  logic irq_q;
  logic irq_d;

  // map synchronised sources onto their flag bit positions
  always_comb begin
    setVec = 8'h00;
    setVec[rcf_pkg::PLL_MONITOR_RESET_FLAG_BIT] = srcSync_q[0];
    setVec[rcf_pkg::OSC_MONITOR_RESET_FLAG_BIT] = srcSync_q[1];
    setVec[rcf_pkg::WATCHDOG_RESET_FLAG_BIT] = srcSync_q[2];
    setVec[rcf_pkg::LOW_VOLTAGE_FLAG_BIT] = lowVoltageSync;
  end

  // write-one clears; a reading access never touches the flags
  always_comb begin
    clrVec = 8'h00;
    if (wrCommit && hitFlags) begin
      clrVec = dat_i[7:0] & rcf_pkg::FLAGS_IMPL_MASK;
    end
    // set after clear so a cause is never lost
    flags_d = ((flags_q & ~clrVec) | setVec) & rcf_pkg::FLAGS_IMPL_MASK;
    mask_d = mask_q;
    if (wrCommit && hitMask) begin
      mask_d = dat_i[7:0] & rcf_pkg::FLAGS_IMPL_MASK;
    end
    irq_d = |(flags_d & mask_d);
  end

  // rst_b is the power-on reset of this always-on block; system
  // resets never reach these flops, so flags survive them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= rcf_pkg::FLAGS_RESET_VAL;
      mask_q <= rcf_pkg::MASK_RESET_VAL;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  assign irq_o = irq_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // every check below sleeps through reset; an attempt that spans the
  // asynchronous assertion of rst_b is dropped rather than failed, so a
  // power-on in mid-run cannot trip a history-based check

  // marks the first clocked cycle after power-on release
  logic firstCyc_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      firstCyc_q <= 1'b1;
    end else begin
      firstCyc_q <= 1'b0;
    end
  end

  logic wrFlags;
  assign wrFlags = wrCommit & hitFlags;

  // power-on flag can only fall, and only via a write-one
  por_flag_hold_a: assert property (
    !flags_q[rcf_pkg::POWER_ON_FLAG_BIT] |=> !flags_q[rcf_pkg::POWER_ON_FLAG_BIT])
    else $error("power-on flag set without power-on reset");

  // low-voltage reset pin reaches the flag within three cycles
  lv_set_a: assert property (
    $rose(flashSupplyLowVoltageReset) ##1 flashSupplyLowVoltageReset[*2]
      |=> flags_q[rcf_pkg::LOW_VOLTAGE_FLAG_BIT])
    else $error("low-voltage flag not set after supply reset");

  // after power-on the low-voltage and power-on flags are set
  por_values_a: assert property (
    firstCyc_q |-> flags_q[rcf_pkg::LOW_VOLTAGE_FLAG_BIT] && flags_q[rcf_pkg::POWER_ON_FLAG_BIT])
    else $error("power-on values of power-on or low-voltage flag wrong");

  // watchdog source reaches its flag one cycle after sync
  wd_set_a: assert property (
    srcSync_q[2] |=> flags_q[rcf_pkg::WATCHDOG_RESET_FLAG_BIT])
    else $error("watchdog reset flag not set");

  // oscillator monitor pin to flag through both sync stages
  osc_set_a: assert property (
    oscMonitorReset ##1 oscMonitorReset |-> ##2 flags_q[rcf_pkg::OSC_MONITOR_RESET_FLAG_BIT])
    else $error("oscillator monitor flag not set");

  // pll monitor source reaches its flag
  pll_set_a: assert property (
    srcSync_q[0] |=> flags_q[rcf_pkg::PLL_MONITOR_RESET_FLAG_BIT])
    else $error("pll monitor flag not set");

  // monitor flags start clear after power-on
  por_clear_a: assert property (
    firstCyc_q |-> (flags_q & 8'h0B) == 8'h00)
    else $error("monitor flags not cleared by power-on");

  // any falling flag needs a write of one to that bit
  clear_cause_a: assert property (
    (($past(flags_q) & ~flags_q) != 8'h00) |->
      $past(wrFlags) && ((($past(flags_q) & ~flags_q) & ~$past(dat_i[7:0])) == 8'h00))
    else $error("flag cleared without write-one");

  // unimplemented bits stay zero in register and read data
  reserved_zero_a: assert property (
    ((flags_q & ~rcf_pkg::FLAGS_IMPL_MASK) == 8'h00) and
      (ack_q && !we_i && hitFlags |->
        (rdData_q & ~{24'h00_0000, rcf_pkg::FLAGS_IMPL_MASK}) == 32'h0000_0000))
    else $error("reserved flag bits not zero");

  // set wins over a simultaneous clear
  set_wins_a: assert property (
    srcSync_q[2] && wrFlags && dat_i[rcf_pkg::WATCHDOG_RESET_FLAG_BIT]
      |=> flags_q[rcf_pkg::WATCHDOG_RESET_FLAG_BIT])
    else $error("clear beat a reset event");

  // ack is a single-cycle pulse
  ack_pulse_a: assert property (
    ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  // interrupt high whenever an unmasked flag is set
  irq_follow_a: assert property (
    |(flags_q & mask_q) |-> irq_o)
    else $error("interrupt low with unmasked flag set");

  // a request with ack low is answered on the very next edge
  ack_answer_a: assert property (
    busReq && !ack_o |=> ack_o)
    else $error("bus request not acknowledged in one cycle");

  // ack only while the master still holds its request
  ack_needs_req_a: assert property (
    ack_o |-> busReq)
    else $error("ack without a standing request");

  // read data shows the flags as they stood when the read was taken
  rdata_flags_a: assert property (
    ack_o && !we_i && hitFlags |-> dat_o[7:0] == $past(flags_q))
    else $error("flag read data wrong");

  // read data only moves when a read is taken
  rdata_hold_a: assert property (
    !(busReq && !we_i && !ack_o) |=> $stable(dat_o))
    else $error("read data changed without a read");

  // a read leaves every flag as it was, apart from new causes
  read_no_effect_a: assert property (
    busReq && !we_i |=> flags_q == ($past(flags_q) | $past(setVec)))
    else $error("read access changed the flags");

  // no flag falls unless that cycle carried a flag write
  flags_sticky_a: assert property (
    !wrFlags |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("flag fell without a write");

  // mask takes the implemented bits of a committed write
  mask_write_a: assert property (
    wrCommit && hitMask |=> mask_q == ($past(dat_i[7:0]) & rcf_pkg::FLAGS_IMPL_MASK))
    else $error("mask write not taken");

  // mask holds when it is not written
  mask_hold_a: assert property (
    !(wrCommit && hitMask) |=> $stable(mask_q))
    else $error("mask changed without a write");

  // unimplemented mask bits stay zero
  mask_reserved_a: assert property (
    (mask_q & ~rcf_pkg::FLAGS_IMPL_MASK) == 8'h00)
    else $error("reserved mask bits not zero");

  // after power-on the mask is clear and the interrupt quiet
  por_mask_a: assert property (
    firstCyc_q |-> mask_q == rcf_pkg::MASK_RESET_VAL && !irq_o)
    else $error("mask or interrupt wrong after power-on");

  // any of the three merged supply requests sets the low-voltage flag
  lv_any_a: assert property (
    lowVoltageSync |=> flags_q[rcf_pkg::LOW_VOLTAGE_FLAG_BIT])
    else $error("merged low-voltage request lost");

  // io supply pin held three cycles reaches the flag
  io_pin_a: assert property (
    ioSupplyLowVoltageReset [*3] |=> flags_q[rcf_pkg::LOW_VOLTAGE_FLAG_BIT])
    else $error("io supply request did not set the flag");

  // watchdog pin held three cycles reaches its flag
  wd_pin_a: assert property (
    watchdogTimerReset [*3] |=> flags_q[rcf_pkg::WATCHDOG_RESET_FLAG_BIT])
    else $error("watchdog request did not set the flag");

  // pll monitor pin held three cycles reaches its flag
  pll_pin_a: assert property (
    pllMonitorReset [*3] |=> flags_q[rcf_pkg::PLL_MONITOR_RESET_FLAG_BIT])
    else $error("pll monitor request did not set the flag");

  // interrupt low whenever no unmasked flag is set
  irq_quiet_a: assert property (
    (flags_q & mask_q) == 8'h00 |-> !irq_o)
    else $error("interrupt high with no unmasked flag");

  // main scenarios
  wd_event_c: cover property (srcSync_q[2] ##1 flags_q[rcf_pkg::WATCHDOG_RESET_FLAG_BIT]);
  w1c_clear_c: cover property (wrFlags && dat_i[rcf_pkg::POWER_ON_FLAG_BIT]
    ##1 !flags_q[rcf_pkg::POWER_ON_FLAG_BIT]);
  irq_raise_c: cover property ($rose(irq_o));
  set_clear_race_c: cover property (srcSync_q[2] && wrFlags && dat_i[rcf_pkg::WATCHDOG_RESET_FLAG_BIT]);
  lv_merge_c: cover property (srcSync_q[5] ##1 flags_q[rcf_pkg::LOW_VOLTAGE_FLAG_BIT]);

endmodule

/* rcf_source_model.sv */
`timescale 1ns/10ps
// ==========================================
// reset source monitors seen from the flag block
module rcf_source_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] fire,
  input wire logic [5:0] hold,
  output logic [5:0] srcLevel
);
  logic [2:0] cnt_q [6];
  logic [2:0] cnt_d [6];
  // a fired monitor holds its request four cycles, long enough for a two-flop synchroniser
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      cnt_d[i] = fire[i] ? 3'h4 : ((cnt_q[i] != 3'h0) ? cnt_q[i] - 3'h1 : 3'h0);
      srcLevel[i] = hold[i] || (cnt_q[i] != 3'h0); // released lines idle low
    end
  end
  // counters only; power-on ends fired requests, but a high hold still drives srcLevel through it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '{default: 3'h0};
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* tb.sv */
`timescale 1ns/10ps
// ==========================================
// flag block bench
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] datO;
  logic ackO;
  logic irqO;
  logic [5:0] fire = 6'h00;
  logic [5:0] hold = 6'h00;
  logic [5:0] src;
  logic [31:0] rd;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  // expected flag bit per source: core, flash, io supply, watchdog, oscillator, pll
  logic [7:0] bitOf [6] = '{8'h20, 8'h20, 8'h20, 8'h08, 8'h02, 8'h01};
  always #2 clk = ~clk;
  rcf_reset_cause_flags dut_u (.clk(clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'h1), .dat_i(dat), .dat_o(datO), .ack_o(ackO), .coreLowVoltageReset(src[0]),
    .flashSupplyLowVoltageReset(src[1]), .ioSupplyLowVoltageReset(src[2]), .watchdogTimerReset(src[3]),
    .oscMonitorReset(src[4]), .pllMonitorReset(src[5]), .irq_o(irqO));
  rcf_source_model model_u (.clk(clk), .rst_b(rst_b), .fire(fire), .hold(hold), .srcLevel(src));
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one classic cycle; request held until ack is seen at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    // if ack never comes, only the hang guard ends this wait
    do begin
      @(posedge clk);
    end while (ackO !== 1'b1);
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic readFlags(input logic [7:0] exp, input string what);
    bus(1'b0, 8'h0C, 8'h00);
    check(rd, {24'h00_0000, exp}, what);
  endtask
  task automatic doReset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  // power-on values, then write-zero and write-one behaviour incl. unused bits
  task automatic testPowerOn();
    readFlags(8'h60, "power-on value");
    bus(1'b1, 8'h0C, 8'h00);
    readFlags(8'h60, "write zero");
    bus(1'b1, 8'h0C, 8'hFF);
    readFlags(8'h00, "write one clear");
  endtask
  // every source sets its own bit only, and the flag outlives the request
  task automatic testSources();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      fire <= 6'h01 << i;
      @(posedge clk);
      fire <= 6'h00;
      repeat (10) @(posedge clk);
      readFlags(bitOf[i], "source flag");
      bus(1'b1, 8'h0C, bitOf[i]);
      readFlags(8'h00, "source clear");
    end
  endtask
  // clear while the watchdog request is still high must lose
  task automatic testSetWins();
    hold <= 6'h08;
    repeat (6) @(posedge clk);
    bus(1'b1, 8'h0C, 8'h08);
    readFlags(8'h08, "set beats clear");
    hold <= 6'h00;
    repeat (6) @(posedge clk);
    bus(1'b1, 8'h0C, 8'h08);
    readFlags(8'h00, "clear after release");
  endtask
  // mask, raise, mask off, clear; plus an unmapped read
  task automatic testIrq();
    bus(1'b1, 8'h10, 8'hFF);
    bus(1'b0, 8'h10, 8'h00);
    check(rd, 32'h0000_006B, "mask bits");
    bus(1'b1, 8'h10, 8'h01);
    fire <= 6'h20;
    @(posedge clk);
    fire <= 6'h00;
    repeat (10) @(posedge clk);
    check({31'h0000_0000, irqO}, 32'h0000_0001, "irq raised");
    bus(1'b1, 8'h10, 8'h00);
    repeat (2) @(posedge clk);
    check({31'h0000_0000, irqO}, 32'h0000_0000, "irq masked");
    bus(1'b1, 8'h10, 8'h01);
    bus(1'b1, 8'h0C, 8'h01);
    repeat (2) @(posedge clk);
    check({31'h0000_0000, irqO}, 32'h0000_0000, "irq cleared");
    bus(1'b0, 8'h20, 8'h00);
    check(rd, 32'h0000_0000, "unmapped read");
  endtask
  // a second power-on clears the watchdog flag and sets power-on again
  task automatic testSecondReset();
    fire <= 6'h08;
    @(posedge clk);
    fire <= 6'h00;
    repeat (10) @(posedge clk);
    doReset();
    readFlags(8'h60, "second power-on");
  endtask
  // main sequence
  initial begin
    doReset();
    testPowerOn();
    testSources();
    testSetWins();
    testIrq();
    testSecondReset();
    tally_and_finish();
  end
endmodule
